// [test/fifo_trigger_ready_ctrl_tb.sv]
// Bench: host sequencer against register bank, thresholds and status readout
`timescale 1ns/100ps
module fifo_trigger_ready_ctrl_tb;
   import ftr_pkg::*;
   logic                      clk, rst, cmdValid, cmdReady, cmdChan, doneValid;
   ftr_cmd_e                  cmdCode;
   logic [15:0]               cmdValue;
   logic [7:0]                doneData;
   logic [1:0][FTR_CNT_W-1:0] txFree, rxCount, txLevel, rxLevel;
   logic [1:0]                rxTimeout, txReady, rxReady, prescaleDiv4, baudEn;
   logic [1:0][15:0]          divisor;
   int                        num_errors, total_checks, cnt;
   int                        expTx[2], expRx[2];
   ftr_bus_if bus ();
   ftr_device u_ftr_device (.clk(clk), .rst(rst), .bus(bus.dev), .txFree(txFree), .rxCount(rxCount),
      .rxTimeout(rxTimeout), .txReady(txReady), .rxReady(rxReady), .txLevel(txLevel), .rxLevel(rxLevel),
      .divisor(divisor), .prescaleDiv4(prescaleDiv4), .baudEn(baudEn));
   ftr_host u_ftr_host (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode),
      .cmdChan(cmdChan), .cmdValue(cmdValue), .doneValid(doneValid), .doneData(doneData), .bus(bus.host));
   ftr_bus_props u_props (.clk(clk), .rst(rst), .channelSelectA_n(bus.channelSelectA_n),
      .channelSelectB_n(bus.channelSelectB_n), .addr(bus.addr), .wrStrobe(bus.wrStrobe),
      .rdStrobe(bus.rdStrobe), .wrData(bus.wrData), .rdData(bus.rdData), .rdValid(bus.rdValid));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // Polls doneValid when forDone is set, cmdReady otherwise
   task automatic waitHigh(input bit forDone, input int lim);
      int n;
      n = 0;
      while ((forDone ? doneValid : cmdReady) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         num_errors++;
         finish_test();
      end
   endtask : waitHigh
   task automatic runCmd(input ftr_cmd_e code, input logic chan, input logic [15:0] val);
      @(negedge clk);
      cmdCode = code;
      cmdChan = chan;
      cmdValue = val;
      cmdValid = 1'b1;
      waitHigh(1'b0, 50);
      @(negedge clk);
      cmdValid = 1'b0;
      waitHigh(1'b1, 100);
   endtask : runCmd
   task automatic checkLevels;
      for (int c = 0; c < 2; c++) begin
         check(16'(txLevel[c]), 16'(expTx[c]));
         check(16'(rxLevel[c]), 16'(expRx[c]));
      end
   endtask : checkLevels
   // Status expected from the bench's own view of levels and occupancy
   function automatic logic [7:0] expRdy();
      logic [1:0] t, r;
      for (int c = 0; c < 2; c++) begin
         t[c] = int'(txFree[c]) >= expTx[c];
         r[c] = int'(rxCount[c]) > expRx[c] || rxTimeout[c];
      end
      return {2'h0, r, 2'h0, t};
   endfunction : expRdy
   initial begin
      rst = 1'b1;
      cmdValid = 1'b0;
      cmdCode = FTR_CMD_DIVISOR;
      cmdChan = 1'b0;
      cmdValue = 16'h0000;
      txFree = '0;
      rxCount = '0;
      rxTimeout = 2'h0;
      expTx = '{8, 8};
      expRx = '{8, 8};
      repeat (4) @(negedge clk);
      rst = 1'b0;
      checkLevels();
      runCmd(FTR_CMD_TRIGGER, 1'b0, 16'h003C);
      expTx[0] = 48;
      expRx[0] = 12;
      checkLevels();
      runCmd(FTR_CMD_TRIGGER, 1'b1, 16'h00F1);
      expTx[1] = 4;
      expRx[1] = 60;
      checkLevels();
      // One below, at and one above each threshold, status read on alternate channels
      for (int i = 0; i < 3; i++) begin
         txFree = {7'(3 + i), 7'(47 + i)};
         rxCount = {7'(59 + i), 7'(11 + i)};
         rxTimeout = {i == 0, 1'b0};
         #1;
         check(16'(txReady), 16'(expRdy() & 8'h03));
         check(16'(rxReady), 16'(expRdy() >> 4));
         runCmd(FTR_CMD_READY, 1'(i), 16'h0000);
         check(16'(doneData), 16'(expRdy()));
      end
      runCmd(FTR_CMD_TRIGGER, 1'b0, 16'h0000);
      runCmd(FTR_CMD_TRIGGER, 1'b1, 16'h0050);
      expTx = '{8, 8};
      expRx = '{8, 20};
      checkLevels();
      runCmd(FTR_CMD_DIVISOR, 1'b1, 16'hA55A);
      check(divisor[1], 16'hA55A);
      check(divisor[0], 16'h0000);
      runCmd(FTR_CMD_PRESCALE, 1'b0, 16'h0001);
      check(16'(prescaleDiv4), 16'h0001);
      cnt = 0;
      repeat (8) begin
         @(negedge clk);
         cnt += int'(baudEn[0]);
      end
      check(16'(cnt), 16'h0002);
      runCmd(FTR_CMD_PRESCALE, 1'b0, 16'h0000);
      check(16'(prescaleDiv4), 16'h0000);
      finish_test();
   end
endmodule : fifo_trigger_ready_ctrl_tb

// [test/ftr_bus_props.sv]
// Bus-level checks on the host-to-bank register bus
`timescale 1ns/100ps
module ftr_bus_props
   import ftr_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Register bus
   input wire logic       channelSelectA_n,
   input wire logic       channelSelectB_n,
   input wire logic [2:0] addr,
   input wire logic       wrStrobe,
   input wire logic       rdStrobe,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic       rdValid
);
   logic [7:0] lastLine;
   logic [7:0] lastModem;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Shadows of the host's own writes tell which register bank is open
   always_ff @(posedge clk) begin
      if (rst) lastLine <= FTR_RST_REG;
      else if (wrStrobe && addr == FTR_A_LINE) lastLine <= wrData;
   end
   always_ff @(posedge clk) begin
      if (rst) lastModem <= FTR_RST_REG;
      else if (wrStrobe && addr == FTR_A_MODEM && lastLine != FTR_LINE_ENH) lastModem <= wrData;
   end
   read_answer_a: assert property ((rdStrobe && !(channelSelectA_n && channelSelectB_n)) |=> rdValid)
      else $error("read not answered");
   valid_cause_a: assert property (rdValid |-> $past(rdStrobe))
      else $error("answer without read");
   data_hold_a: assert property (!rdValid |-> $stable(rdData))
      else $error("read data moved");
   strobe_excl_a: assert property (!(wrStrobe && rdStrobe))
      else $error("both strobes");
   one_select_a: assert property ((wrStrobe || rdStrobe) |-> (channelSelectA_n != channelSelectB_n))
      else $error("bad selects");
   divisor_gate_a: assert property ((wrStrobe && addr <= FTR_A_DIV_HI) |-> lastLine == FTR_LINE_DIV)
      else $error("divisor write outside latch mode");
   enh_gate_a: assert property ((wrStrobe && addr == FTR_A_ENH) |-> lastLine == FTR_LINE_ENH)
      else $error("enhanced write outside key");
   trigger_gate_a: assert property ((wrStrobe && addr == FTR_A_TRIG) |->
                                    lastModem[FTR_MODEM_EXT_BIT] && lastLine == FTR_LINE_NORM)
      else $error("trigger write outside extended mode");
   ready_gate_a: assert property ((rdStrobe && addr == FTR_A_TRIG) |->
                                  lastModem[FTR_MODEM_RDY_BIT] && !lastModem[FTR_MODEM_LOOP_BIT])
      else $error("status read without enable");
   ready_zero_a: assert property ((rdStrobe && addr == 3'h7) |=> rdData[7:6] == 2'h0 && rdData[3:2] == 2'h0)
      else $error("unused status bits set");
   cover property (wrStrobe && addr == 3'h0);
   cover property (wrStrobe && addr == 3'h7);
   cover property (rdStrobe && addr == 3'h7);
endmodule : ftr_bus_props

// [verilog/ftr_bus_if.sv]
// Parallel 8-bit register bus between host sequencer and register bank
`timescale 1ns/100ps
interface ftr_bus_if;
   logic       channelSelectA_n;
   logic       channelSelectB_n;
   logic [2:0] addr;
   logic       wrStrobe;
   logic       rdStrobe;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic       rdValid;

   modport dev (
      input  channelSelectA_n,
      input  channelSelectB_n,
      input  addr,
      input  wrStrobe,
      input  rdStrobe,
      input  wrData,
      output rdData,
      output rdValid
   );

   modport host (
      output channelSelectA_n,
      output channelSelectB_n,
      output addr,
      output wrStrobe,
      output rdStrobe,
      output wrData,
      input  rdData,
      input  rdValid
   );
endinterface : ftr_bus_if

// [verilog/ftr_device.sv]
// Dual-channel register bank: trigger levels, ready status and extended-register gating
`timescale 1ns/100ps
module ftr_device
   import ftr_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Register bus
   ftr_bus_if.dev                         bus,
   // FIFO occupancy per channel (0 = A, 1 = B)
   input  wire logic [1:0][FTR_CNT_W-1:0] txFree,
   input  wire logic [1:0][FTR_CNT_W-1:0] rxCount,
   input  wire logic [1:0]                rxTimeout,
   // Threshold results for DMA and interrupt logic
   output logic      [1:0]                txReady,
   output logic      [1:0]                rxReady,
   output logic      [1:0][FTR_CNT_W-1:0] txLevel,
   output logic      [1:0][FTR_CNT_W-1:0] rxLevel,
   // Baud path controls
   output logic      [1:0][15:0]          divisor,
   output logic      [1:0]                prescaleDiv4,
   output logic      [1:0]                baudEn
);

   logic [7:0] lineCtrl   [2];
   logic [7:0] enhFeature [2];
   logic [7:0] modemCtrl  [2];
   logic [7:0] fifoCtrl   [2];
   logic [7:0] intEnable  [2];
   logic [7:0] divLo      [2];
   logic [7:0] divHi      [2];
   logic [7:0] onCharOne  [2];
   logic [7:0] onCharTwo  [2];
   logic [7:0] offCharOne [2];
   logic [7:0] offCharTwo [2];
   logic [7:0] flowThresh [2];
   logic [7:0] trigLevels [2];
   logic [7:0] scratch    [2];
   logic [1:0] preCnt     [2];
   logic [1:0] chanSel;
   logic       anySel;
   logic       rdChan;
   logic [7:0] readyStatus;
   logic [7:0] next_rdData;

   assign chanSel = {~bus.channelSelectB_n, ~bus.channelSelectA_n};
   assign anySel  = |chanSel;
   // Channel A wins a read when both selects are low
   assign rdChan  = ~chanSel[0];

   function automatic logic divMode(input logic [7:0] lineReg);
      divMode = lineReg[7];
   endfunction : divMode

   function automatic logic enhMode(input logic [7:0] lineReg);
      enhMode = (lineReg == FTR_LINE_ENH);
   endfunction : enhMode

   function automatic logic extMode(input logic [7:0] enhReg, input logic [7:0] modemReg);
      extMode = enhReg[FTR_ENH_ON_BIT] & modemReg[FTR_MODEM_EXT_BIT];
   endfunction : extMode

   // Register writes, one bank per channel; both banks take a write when both selects are low
   always_ff @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         if (rst) begin
            lineCtrl[c]   <= FTR_RST_REG;
            enhFeature[c] <= FTR_RST_REG;
            modemCtrl[c]  <= FTR_RST_REG;
            fifoCtrl[c]   <= FTR_RST_REG;
            intEnable[c]  <= FTR_RST_REG;
            divLo[c]      <= FTR_RST_REG;
            divHi[c]      <= FTR_RST_REG;
            onCharOne[c]  <= FTR_RST_REG;
            onCharTwo[c]  <= FTR_RST_REG;
            offCharOne[c] <= FTR_RST_REG;
            offCharTwo[c] <= FTR_RST_REG;
            flowThresh[c] <= FTR_RST_REG;
            trigLevels[c] <= FTR_RST_REG;
            scratch[c]    <= FTR_RST_REG;
         end else if (bus.wrStrobe && chanSel[c]) begin
            unique case (bus.addr)
               3'h0: begin
                  if (divMode(lineCtrl[c])) divLo[c] <= bus.wrData;
               end
               3'h1: begin
                  if (divMode(lineCtrl[c])) begin
                     divHi[c] <= bus.wrData;
                  end else if (enhFeature[c][FTR_ENH_ON_BIT]) begin
                     intEnable[c] <= bus.wrData;
                  end else begin
                     intEnable[c] <= {intEnable[c][7:4], bus.wrData[3:0]};
                  end
               end
               3'h2: begin
                  if (enhMode(lineCtrl[c])) begin
                     enhFeature[c] <= bus.wrData;
                  end else if (enhFeature[c][FTR_ENH_ON_BIT]) begin
                     fifoCtrl[c] <= bus.wrData;
                  end else begin
                     fifoCtrl[c] <= {bus.wrData[7:6], fifoCtrl[c][5:4], bus.wrData[3:0]};
                  end
               end
               3'h3: lineCtrl[c] <= bus.wrData;
               3'h4: begin
                  if (enhMode(lineCtrl[c])) begin
                     onCharOne[c] <= bus.wrData;
                  end else if (enhFeature[c][FTR_ENH_ON_BIT]) begin
                     modemCtrl[c] <= bus.wrData;
                  end else begin
                     modemCtrl[c] <= {modemCtrl[c][7:5], bus.wrData[4:0]};
                  end
               end
               3'h5: begin
                  if (enhMode(lineCtrl[c])) onCharTwo[c] <= bus.wrData;
               end
               3'h6: begin
                  if (enhMode(lineCtrl[c])) begin
                     offCharOne[c] <= bus.wrData;
                  end else if (extMode(enhFeature[c], modemCtrl[c])) begin
                     flowThresh[c] <= bus.wrData;
                  end
               end
               3'h7: begin
                  if (enhMode(lineCtrl[c])) begin
                     offCharTwo[c] <= bus.wrData;
                  end else if (extMode(enhFeature[c], modemCtrl[c])) begin
                     trigLevels[c] <= bus.wrData;
                  end else begin
                     scratch[c] <= bus.wrData;
                  end
               end
            endcase
         end
      end
   end

   // Live thresholds; nothing here is latched, so DMA sees every FIFO change at once
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         txLevel[c] = ftrLevel(trigLevels[c][3:0], fifoCtrl[c][5:4]);
         rxLevel[c] = ftrLevel(trigLevels[c][7:4], fifoCtrl[c][7:6]);
         txReady[c] = (txFree[c] >= txLevel[c]);
         rxReady[c] = (rxCount[c] > rxLevel[c]) | rxTimeout[c];
         divisor[c] = {divHi[c], divLo[c]};
         prescaleDiv4[c] = modemCtrl[c][FTR_MODEM_PRE_BIT];
      end
   end

   assign readyStatus = {2'h0, rxReady, 2'h0, txReady};

   // Read mux for the channel picked by the selects
   always_comb begin
      next_rdData = FTR_RST_REG;
      unique case (bus.addr)
         3'h0: next_rdData = divMode(lineCtrl[rdChan]) ? divLo[rdChan] : FTR_RST_REG;
         3'h1: next_rdData = divMode(lineCtrl[rdChan]) ? divHi[rdChan] : intEnable[rdChan];
         3'h2: begin
            if (enhMode(lineCtrl[rdChan])) begin
               next_rdData = enhFeature[rdChan];
            end else begin
               next_rdData = {{2{fifoCtrl[rdChan][FTR_FIFO_EN_BIT]}}, 6'h01};
            end
         end
         3'h3: next_rdData = lineCtrl[rdChan];
         3'h4: next_rdData = enhMode(lineCtrl[rdChan]) ? onCharOne[rdChan] : modemCtrl[rdChan];
         3'h5: next_rdData = enhMode(lineCtrl[rdChan]) ? onCharTwo[rdChan] : FTR_RST_REG;
         3'h6: begin
            if (enhMode(lineCtrl[rdChan])) begin
               next_rdData = offCharOne[rdChan];
            end else if (extMode(enhFeature[rdChan], modemCtrl[rdChan])) begin
               next_rdData = flowThresh[rdChan];
            end
         end
         3'h7: begin
            if (modemCtrl[rdChan][FTR_MODEM_RDY_BIT] && !modemCtrl[rdChan][FTR_MODEM_LOOP_BIT]) begin
               next_rdData = readyStatus;
            end else if (enhMode(lineCtrl[rdChan])) begin
               next_rdData = offCharTwo[rdChan];
            end else if (extMode(enhFeature[rdChan], modemCtrl[rdChan])) begin
               next_rdData = trigLevels[rdChan];
            end else begin
               next_rdData = scratch[rdChan];
            end
         end
      endcase
   end

   // Read data lands one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         bus.rdData  <= FTR_RST_REG;
         bus.rdValid <= 1'b0;
      end else begin
         bus.rdValid <= bus.rdStrobe & anySel;
         if (bus.rdStrobe && anySel) bus.rdData <= next_rdData;
      end
   end

   // Prescaler: enable every cycle in divide-by-one, every fourth cycle in divide-by-four
   always_ff @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         if (rst) begin
            preCnt[c] <= 2'h0;
         end else begin
            preCnt[c] <= preCnt[c] + 2'h1;
         end
      end
   end

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         baudEn[c] = !prescaleDiv4[c] || (preCnt[c] == 2'(FTR_PRE_DIV - 1));
      end
   end

endmodule : ftr_device

// [verilog/ftr_host.sv]
// Host sequencer: runs the register access sequences for divisor, triggers, ready status, prescaler
`timescale 1ns/100ps
module ftr_host
   import ftr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Command port
   input  wire logic        cmdValid,
   output logic             cmdReady,
   input  wire ftr_cmd_e    cmdCode,
   input  wire logic        cmdChan,
   input  wire logic [15:0] cmdValue,
   output logic             doneValid,
   output logic [7:0]       doneData,
   // Register bus
   ftr_bus_if.host          bus
);

   typedef enum logic [1:0] {
      FTR_S_IDLE  = 2'b00,
      FTR_S_ISSUE = 2'b01,
      FTR_S_WAIT  = 2'b11,
      FTR_S_DONE  = 2'b10
   } ftr_state_e;

   typedef enum logic [2:0] {
      FTR_OP_RD, FTR_OP_WRK, FTR_OP_WROR, FTR_OP_WRAND, FTR_OP_WRV, FTR_OP_CLR, FTR_OP_RDRET, FTR_OP_END
   } ftr_op_e;

   typedef struct packed {
      ftr_op_e    op;
      logic [2:0] addr;
      logic [1:0] tmp;
      logic [7:0] k;
   } ftr_step_s;

   ftr_state_e state;
   ftr_cmd_e   curCmd;
   logic       curChan;
   logic [15:0] curValue;
   logic [3:0] idx;
   logic [7:0] tmp [3];
   ftr_step_s  step;

   function automatic ftr_step_s mk(input ftr_op_e op, input logic [2:0] a, input logic [1:0] t,
                                    input logic [7:0] k);
      mk = '{op: op, addr: a, tmp: t, k: k};
   endfunction : mk

   // Unlock sequence shared by trigger and prescaler commands
   function automatic ftr_step_s unlockStep(input logic [3:0] i);
      unique case (i)
         4'h0:    unlockStep = mk(FTR_OP_RD,   FTR_A_LINE,  2'h0, FTR_K_ZERO);
         4'h1:    unlockStep = mk(FTR_OP_WRK,  FTR_A_LINE,  2'h0, FTR_LINE_ENH);
         4'h2:    unlockStep = mk(FTR_OP_RD,   FTR_A_ENH,   2'h1, FTR_K_ZERO);
         4'h3:    unlockStep = mk(FTR_OP_WROR, FTR_A_ENH,   2'h1, FTR_K_ENH);
         4'h4:    unlockStep = mk(FTR_OP_WRK,  FTR_A_LINE,  2'h0, FTR_LINE_NORM);
         default: unlockStep = mk(FTR_OP_RD,   FTR_A_MODEM, 2'h2, FTR_K_ZERO);
      endcase
   endfunction : unlockStep

   function automatic ftr_step_s stepOf(input ftr_cmd_e cmd, input logic [3:0] i, input logic div4);
      stepOf = mk(FTR_OP_END, 3'h0, 2'h0, FTR_K_ZERO);
      unique case (cmd)
         FTR_CMD_DIVISOR: begin
            unique case (i)
               4'h0: stepOf = mk(FTR_OP_RD,   FTR_A_LINE,   2'h0, FTR_K_ZERO);
               4'h1: stepOf = mk(FTR_OP_WRK,  FTR_A_LINE,   2'h0, FTR_LINE_DIV);
               4'h2: stepOf = mk(FTR_OP_WRV,  FTR_A_DIV_LO, 2'h0, FTR_K_ZERO);
               4'h3: stepOf = mk(FTR_OP_WRV,  FTR_A_DIV_HI, 2'h1, FTR_K_ZERO);
               4'h4: stepOf = mk(FTR_OP_WROR, FTR_A_LINE,   2'h0, FTR_K_ZERO);
               default: ;
            endcase
         end
         FTR_CMD_TRIGGER, FTR_CMD_PRESCALE: begin
            if (i < 4'h6) begin
               stepOf = unlockStep(i);
            end else begin
               unique case (i)
                  4'h6: stepOf = mk(FTR_OP_WROR, FTR_A_MODEM, 2'h2, FTR_K_EXT);
                  4'h7: begin
                     if (cmd == FTR_CMD_TRIGGER) begin
                        stepOf = mk(FTR_OP_WRV, FTR_A_TRIG, 2'h0, FTR_K_ZERO);
                     end else if (div4) begin
                        stepOf = mk(FTR_OP_WROR, FTR_A_MODEM, 2'h2, FTR_K_PRE4);
                     end else begin
                        stepOf = mk(FTR_OP_WRAND, FTR_A_MODEM, 2'h2, FTR_K_PRE1);
                     end
                  end
                  4'h8: begin
                     if (cmd == FTR_CMD_TRIGGER) stepOf = mk(FTR_OP_WROR, FTR_A_MODEM, 2'h2, FTR_K_ZERO);
                     else stepOf = mk(FTR_OP_WRK, FTR_A_LINE, 2'h0, FTR_LINE_ENH);
                  end
                  4'h9: begin
                     if (cmd == FTR_CMD_TRIGGER) stepOf = mk(FTR_OP_WRK, FTR_A_LINE, 2'h0, FTR_LINE_ENH);
                     else stepOf = mk(FTR_OP_WROR, FTR_A_ENH, 2'h1, FTR_K_ZERO);
                  end
                  4'hA: begin
                     if (cmd == FTR_CMD_TRIGGER) stepOf = mk(FTR_OP_WROR, FTR_A_ENH, 2'h1, FTR_K_ZERO);
                     else stepOf = mk(FTR_OP_WROR, FTR_A_LINE, 2'h0, FTR_K_ZERO);
                  end
                  4'hB: begin
                     if (cmd == FTR_CMD_TRIGGER) stepOf = mk(FTR_OP_WROR, FTR_A_LINE, 2'h0, FTR_K_ZERO);
                  end
                  default: ;
               endcase
            end
         end
         FTR_CMD_READY: begin
            unique case (i)
               4'h0: stepOf = mk(FTR_OP_RD,    FTR_A_MODEM, 2'h0, FTR_K_ZERO);
               4'h1: stepOf = mk(FTR_OP_CLR,   FTR_A_MODEM, 2'h1, FTR_K_NOLOOP);
               4'h2: stepOf = mk(FTR_OP_WROR,  FTR_A_MODEM, 2'h1, FTR_K_RDY);
               4'h3: stepOf = mk(FTR_OP_RDRET, FTR_A_TRIG,  2'h0, FTR_K_ZERO);
               4'h4: stepOf = mk(FTR_OP_WROR,  FTR_A_MODEM, 2'h0, FTR_K_ZERO);
               default: ;
            endcase
         end
      endcase
   endfunction : stepOf

   assign step     = stepOf(curCmd, idx, curValue[0]);
   assign cmdReady = (state == FTR_S_IDLE);

   // Bus drive decoded from the current step
   always_comb begin
      bus.channelSelectA_n = !((state == FTR_S_ISSUE) && !curChan);
      bus.channelSelectB_n = !((state == FTR_S_ISSUE) && curChan);
      bus.addr             = step.addr;
      bus.rdStrobe         = (state == FTR_S_ISSUE) && (step.op == FTR_OP_RD || step.op == FTR_OP_RDRET);
      bus.wrStrobe         = (state == FTR_S_ISSUE) && (step.op inside {FTR_OP_WRK, FTR_OP_WROR,
                                                                         FTR_OP_WRAND, FTR_OP_WRV});
      unique case (step.op)
         FTR_OP_WRK:   bus.wrData = step.k;
         FTR_OP_WROR:  bus.wrData = tmp[step.tmp] | step.k;
         FTR_OP_WRAND: bus.wrData = tmp[step.tmp] & step.k;
         FTR_OP_WRV:   bus.wrData = step.tmp[0] ? curValue[15:8] : curValue[7:0];
         default:      bus.wrData = FTR_K_ZERO;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= FTR_S_IDLE;
         idx       <= 4'h0;
         curCmd    <= FTR_CMD_DIVISOR;
         curChan   <= 1'b0;
         curValue  <= 16'h0000;
         doneValid <= 1'b0;
      end else begin
         doneValid <= 1'b0;
         unique case (state)
            FTR_S_IDLE: begin
               if (cmdValid) begin
                  curCmd   <= cmdCode;
                  curChan  <= cmdChan;
                  curValue <= cmdValue;
                  idx      <= 4'h0;
                  state    <= FTR_S_ISSUE;
               end
            end
            FTR_S_ISSUE: begin
               if (step.op == FTR_OP_END) begin
                  state <= FTR_S_DONE;
               end else if (bus.rdStrobe) begin
                  state <= FTR_S_WAIT;
               end else begin
                  idx <= idx + 4'h1;
               end
            end
            FTR_S_WAIT: begin
               if (bus.rdValid) begin
                  idx   <= idx + 4'h1;
                  state <= FTR_S_ISSUE;
               end
            end
            FTR_S_DONE: begin
               doneValid <= 1'b1;
               state     <= FTR_S_IDLE;
            end
         endcase
      end
   end

   // Saved values and the returned byte
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int t = 0; t < 3; t++) tmp[t] <= FTR_K_ZERO;
         doneData <= FTR_K_ZERO;
      end else if (state == FTR_S_WAIT && bus.rdValid) begin
         if (step.op == FTR_OP_RDRET) doneData <= bus.rdData;
         else tmp[step.tmp] <= bus.rdData;
      end else if (state == FTR_S_ISSUE && step.op == FTR_OP_CLR) begin
         tmp[step.tmp] <= tmp[0] & step.k;
      end
   end

endmodule : ftr_host

// [verilog/ftr_pkg.sv]
// Shared constants for the trigger-level and ready-status register bank and its host sequencer
package ftr_pkg;
   // Register addresses on the 3-bit bus
   localparam logic [2:0] FTR_A_DIV_LO   = 3'h0;
   localparam logic [2:0] FTR_A_DIV_HI   = 3'h1;
   localparam logic [2:0] FTR_A_INTEN    = 3'h1;
   localparam logic [2:0] FTR_A_ENH      = 3'h2;
   localparam logic [2:0] FTR_A_LINE     = 3'h3;
   localparam logic [2:0] FTR_A_MODEM    = 3'h4;
   localparam logic [2:0] FTR_A_ON_TWO   = 3'h5;
   localparam logic [2:0] FTR_A_FLOW     = 3'h6;
   localparam logic [2:0] FTR_A_TRIG     = 3'h7;
   // Line control keys
   localparam logic [7:0] FTR_LINE_DIV   = 8'h80;
   localparam logic [7:0] FTR_LINE_ENH   = 8'hBF;
   localparam logic [7:0] FTR_LINE_NORM  = 8'h00;
   // Bit positions
   localparam int FTR_ENH_ON_BIT     = 4;
   localparam int FTR_MODEM_RDY_BIT  = 2;
   localparam int FTR_MODEM_LOOP_BIT = 4;
   localparam int FTR_MODEM_EXT_BIT  = 6;
   localparam int FTR_MODEM_PRE_BIT  = 7;
   localparam int FTR_FIFO_EN_BIT    = 0;
   // Host-side masks
   localparam logic [7:0] FTR_K_ENH      = 8'h10;
   localparam logic [7:0] FTR_K_EXT      = 8'h40;
   localparam logic [7:0] FTR_K_RDY      = 8'h04;
   localparam logic [7:0] FTR_K_NOLOOP   = 8'hEF;
   localparam logic [7:0] FTR_K_PRE4     = 8'h80;
   localparam logic [7:0] FTR_K_PRE1     = 8'h7F;
   localparam logic [7:0] FTR_K_ZERO     = 8'h00;
   // Reset values
   localparam logic [7:0] FTR_RST_REG    = 8'h00;
   // FIFO level arithmetic and prescaler divide ratio
   localparam int FTR_CNT_W        = 7;
   localparam int FTR_PRE_DIV      = 4;
   // Host commands
   typedef enum logic [1:0] {
      FTR_CMD_DIVISOR  = 2'h0,
      FTR_CMD_TRIGGER  = 2'h1,
      FTR_CMD_READY    = 2'h2,
      FTR_CMD_PRESCALE = 2'h3
   } ftr_cmd_e;

   // Default trigger level chosen by a two-bit FIFO-control field: (sel+1)*8
   // Three-bit sum so that the top selection gives 32 instead of wrapping to zero
   function automatic logic [FTR_CNT_W-1:0] ftrFifoCtrlLevel(input logic [1:0] sel);
      ftrFifoCtrlLevel = {1'b0, 3'(sel) + 3'h1, 3'h0};
   endfunction : ftrFifoCtrlLevel

   // Nibble programmed as level/4, zero means fall back to the FIFO-control level
   function automatic logic [FTR_CNT_W-1:0] ftrLevel(input logic [3:0] nib, input logic [1:0] sel);
      ftrLevel = (nib != 4'h0) ? {1'b0, nib, 2'h0} : ftrFifoCtrlLevel(sel);
   endfunction : ftrLevel
endpackage : ftr_pkg
